// *** src/qdc_defs.svh ***
// register map, field positions, reset values and timing counts of the decoder
`ifndef QDC_DEFS_SVH
`define QDC_DEFS_SVH

// ====================================================================
// register byte offsets
`define QDC_OFS_CTRL 12'h000
`define QDC_OFS_COUNT 12'h004
`define QDC_OFS_STATUS 12'h008
`define QDC_OFS_MASK 12'h00C

// ====================================================================
// control fields
`define QDC_CTRL_RUN 0
`define QDC_CTRL_SIZE_LO 1
`define QDC_CTRL_RES_LO 3
`define QDC_CTRL_INDEX_EN 5
`define QDC_CTRL_FILT_EN 6
`define QDC_SIZE_8 2'h0
`define QDC_SIZE_16 2'h1
`define QDC_SIZE_32 2'h2
`define QDC_RES_1X 2'h0
`define QDC_RES_2X 2'h1
`define QDC_RES_4X 2'h2

// ====================================================================
// event bits, shared by status and mask
`define QDC_EV_OVF 0
`define QDC_EV_UNF 1
`define QDC_EV_IDX 2
`define QDC_EV_BAD 3
`define QDC_EV_WIDTH 8
`define QDC_MASK_FORCED 8'h07

// ====================================================================
// reset values
`define QDC_RST_SIZE 2'h1
`define QDC_RST_RES 2'h2
`define QDC_RST_INDEX_EN 1'b1
`define QDC_RST_FILT_EN 1'b1
`define QDC_RST_MASK 8'h00
`define QDC_FILT_TAPS 3

`endif

// *** src/qdc_pkg.sv ***
// shared types of the quadrature decoder
`default_nettype none
package qdc_pkg;
   typedef logic [15:0] qdc_cnt_t;
   typedef logic [7:0] qdc_ev_t;
   typedef logic [1:0] qdc_sel_t;
endpackage : qdc_pkg
`default_nettype wire

// *** src/qdc_input_filter.sv ***
// pin synchroniser and optional three-sample glitch filter for one encoder input
`timescale 1ns/1ns
`default_nettype none
`include "qdc_defs.svh"

module qdc_input_filter (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic raw_i,
   input wire logic filt_en_i,
   output logic level_o
);
   logic s1;
   logic s2;
   logic s3;
   logic synced;
   logic [`QDC_FILT_TAPS-1:0] hist;

   // ====================================================================
   // synchroniser: a change is accepted once stages two and three agree
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s1 <= 1'b0;
         s2 <= 1'b0;
         s3 <= 1'b0;
         synced <= 1'b0;
      end else begin
         s1 <= raw_i;
         s2 <= s1;
         s3 <= s2;
         if (s2 == s3) begin
            synced <= s3;
         end
      end
   end

   // ====================================================================
   // glitch filter
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         hist <= '0;
         level_o <= 1'b0;
      end else begin
         hist <= {hist[`QDC_FILT_TAPS-2:0], synced};
         if (!filt_en_i) begin
            level_o <= synced;
         end else if (&hist || ~|hist) begin
            level_o <= hist[0];
         end
      end
   end

   a_filter_agree: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (filt_en_i && $past(filt_en_i) && $changed(level_o)) |->
      ($past(hist) == {`QDC_FILT_TAPS{level_o}}))
      else $error("filtered level changed without three agreeing samples");
endmodule : qdc_input_filter
`default_nettype wire

// *** src/qdc_phase_step.sv ***
// decodes one sampled phase transition into up, down or invalid step
`timescale 1ns/1ns
`default_nettype none
`include "qdc_defs.svh"

module qdc_phase_step (
   input wire logic prev_a_i,
   input wire logic prev_b_i,
   input wire logic a_i,
   input wire logic b_i,
   input wire logic [1:0] res_i,
   output logic up_o,
   output logic down_o,
   output logic bad_o
);
   logic [1:0] p_old;
   logic [1:0] p_new;
   logic [1:0] diff;
   logic fwd;
   logic rev;

   // position along the cycle 00,01,11,10 (b leading a counts forward)
   function automatic logic [1:0] pos(input logic a, input logic b);
      pos = {a, a ^ b};
   endfunction : pos

   always_comb begin
      p_old = pos(prev_a_i, prev_b_i);
      p_new = pos(a_i, b_i);
      diff = p_new - p_old;
      fwd = (diff == 2'h1);
      rev = (diff == 2'h3);
      bad_o = (diff == 2'h2);
      up_o = 1'b0;
      down_o = 1'b0;
      // lower resolutions count only steps touching position 0 (1x) or even ones (2x)
      unique case (res_i)
         `QDC_RES_1X: begin
            up_o = fwd && (p_new == 2'h0);
            down_o = rev && (p_old == 2'h0);
         end
         `QDC_RES_2X: begin
            up_o = fwd && !p_new[0];
            down_o = rev && !p_old[0];
         end
         default: begin
            up_o = fwd;
            down_o = rev;
         end
      endcase
   end
endmodule : qdc_phase_step
`default_nettype wire

// *** src/qdc_top.sv ***
// quadrature decoder with apb register access
// Functional notes
// - start zeroes count; interrupt enables apply as soon as the mask is written
// - running: sample phases, count qualifying transitions
// - stop halts counting; the phases are still sampled
// - count reads back signed at 8 bits for 8-bit size, at 16 bits for 16- and 32-bit size
// - b leading a counts up
// - count write loads value, counting continues
// - 8-bit status, cleared by reading
// - flags: overflow, underflow, index reset, invalid step
// - interrupt only for enabled events
// - 8-bit mask, same bit positions, 1 enables
// - 32-bit size: three mask bits forced on
// - mask readable, forced bits read one
// - index with a, b low zeroes count
// - glitch filter needs three agreeing samples
// - resolution selectable 1x, 2x, 4x
// - 32-bit size counts low sixteen bits
`timescale 1ns/1ns
`default_nettype none
`include "qdc_defs.svh"

module qdc_top (
   input wire logic core_clk_i,
   input wire logic rstn_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [11:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic phase_a_i,
   input wire logic phase_b_i,
   input wire logic index_i,
   output logic irq_o
);
   // ====================================================================
   // reset release
   logic rst_q1;
   logic rst_n;

   always_ff @(posedge core_clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rst_q1 <= 1'b0;
         rst_n <= 1'b0;
      end else begin
         rst_q1 <= 1'b1;
         rst_n <= rst_q1;
      end
   end

   // ====================================================================
   // configuration and state
   logic run;
   qdc_pkg::qdc_sel_t size_sel;
   qdc_pkg::qdc_sel_t res_sel;
   logic index_en;
   logic filt_en;
   qdc_pkg::qdc_ev_t mask;
   qdc_pkg::qdc_ev_t eff_mask;
   qdc_pkg::qdc_ev_t status;
   qdc_pkg::qdc_ev_t ev;
   qdc_pkg::qdc_cnt_t count;
   qdc_pkg::qdc_cnt_t next_count;
   logic is32;
   logic is8;

   assign is32 = (size_sel == `QDC_SIZE_32);
   assign is8 = (size_sel == `QDC_SIZE_8);
   // forced enables show in the readback as well as in the gating
   assign eff_mask = is32 ? (mask | `QDC_MASK_FORCED) : mask;

   // ====================================================================
   // apb slave: answer prepared in the setup cycle, one access cycle
   logic acc;
   logic wr_ctrl;
   logic wr_count;
   logic wr_mask;
   logic rd_status;
   logic start_cmd;
   logic mapped;
   logic [31:0] rd_val;
   qdc_pkg::qdc_ev_t shown;

   assign acc = psel_i && penable_i && pready_o;
   assign wr_ctrl = acc && pwrite_i && (paddr_i == `QDC_OFS_CTRL);
   assign wr_count = acc && pwrite_i && (paddr_i == `QDC_OFS_COUNT);
   assign wr_mask = acc && pwrite_i && (paddr_i == `QDC_OFS_MASK);
   assign rd_status = acc && !pwrite_i && (paddr_i == `QDC_OFS_STATUS);
   assign start_cmd = wr_ctrl && pwdata_i[`QDC_CTRL_RUN];

   always_comb begin
      mapped = 1'b1;
      rd_val = 32'h0000_0000;
      unique case (paddr_i)
         `QDC_OFS_CTRL: begin
            rd_val[`QDC_CTRL_RUN] = run;
            rd_val[`QDC_CTRL_SIZE_LO +: 2] = size_sel;
            rd_val[`QDC_CTRL_RES_LO +: 2] = res_sel;
            rd_val[`QDC_CTRL_INDEX_EN] = index_en;
            rd_val[`QDC_CTRL_FILT_EN] = filt_en;
         end
         `QDC_OFS_COUNT: begin
            if (is8) begin
               rd_val = {{24{count[7]}}, count[7:0]};
            end else begin
               rd_val = {{16{count[15]}}, count};
            end
         end
         `QDC_OFS_STATUS: rd_val[7:0] = status;
         `QDC_OFS_MASK: rd_val[7:0] = eff_mask;
         default: mapped = 1'b0;
      endcase
   end

   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         pready_o <= 1'b0;
         pslverr_o <= 1'b0;
         prdata_o <= 32'h0000_0000;
         shown <= 8'h00;
      end else begin
         pready_o <= psel_i && !penable_i;
         if (psel_i && !penable_i) begin
            pslverr_o <= !mapped;
            prdata_o <= pwrite_i ? 32'h0000_0000 : rd_val;
            // only what the reader is handed gets cleared later
            shown <= (paddr_i == `QDC_OFS_STATUS) ? status : 8'h00;
         end
      end
   end

   // ====================================================================
   // control register
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         run <= 1'b0;
         size_sel <= `QDC_RST_SIZE;
         res_sel <= `QDC_RST_RES;
         index_en <= `QDC_RST_INDEX_EN;
         filt_en <= `QDC_RST_FILT_EN;
      end else if (wr_ctrl) begin
         run <= pwdata_i[`QDC_CTRL_RUN];
         size_sel <= pwdata_i[`QDC_CTRL_SIZE_LO +: 2];
         res_sel <= pwdata_i[`QDC_CTRL_RES_LO +: 2];
         index_en <= pwdata_i[`QDC_CTRL_INDEX_EN];
         filt_en <= pwdata_i[`QDC_CTRL_FILT_EN];
      end
   end

   // ====================================================================
   // interrupt mask
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         mask <= `QDC_RST_MASK;
      end else if (wr_mask) begin
         if (is32) begin
            mask <= {pwdata_i[7:3], mask[2:0]};
         end else begin
            mask <= pwdata_i[7:0];
         end
      end
   end

   // ====================================================================
   // inputs and step decode
   logic a_lvl;
   logic b_lvl;
   logic i_lvl;
   logic prev_a;
   logic prev_b;
   logic step_up;
   logic step_dn;
   logic step_bad;
   logic idx_hit;

   qdc_input_filter u_filt_a (
      .clk_i(core_clk_i),
      .rst_n_i(rst_n),
      .raw_i(phase_a_i),
      .filt_en_i(filt_en),
      .level_o(a_lvl)
   );
   qdc_input_filter u_filt_b (
      .clk_i(core_clk_i),
      .rst_n_i(rst_n),
      .raw_i(phase_b_i),
      .filt_en_i(filt_en),
      .level_o(b_lvl)
   );
   qdc_input_filter u_filt_i (
      .clk_i(core_clk_i),
      .rst_n_i(rst_n),
      .raw_i(index_i),
      .filt_en_i(filt_en),
      .level_o(i_lvl)
   );

   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         prev_a <= 1'b0;
         prev_b <= 1'b0;
      end else begin
         prev_a <= a_lvl;
         prev_b <= b_lvl;
      end
   end

   qdc_phase_step u_step (
      .prev_a_i(prev_a),
      .prev_b_i(prev_b),
      .a_i(a_lvl),
      .b_i(b_lvl),
      .res_i(res_sel),
      .up_o(step_up),
      .down_o(step_dn),
      .bad_o(step_bad)
   );

   assign idx_hit = run && index_en && !a_lvl && !b_lvl && !i_lvl;

   // ====================================================================
   // position counter; 8-bit mode keeps the upper byte as a sign copy
   logic at_max;
   logic at_min;
   qdc_pkg::qdc_cnt_t cnt_inc;
   qdc_pkg::qdc_cnt_t cnt_dec;

   assign at_max = is8 ? (count[7:0] == 8'h7F) : (count == 16'h7FFF);
   assign at_min = is8 ? (count[7:0] == 8'h80) : (count == 16'h8000);
   assign cnt_inc = count + 16'h0001;
   assign cnt_dec = count - 16'h0001;

   always_comb begin
      next_count = count;
      ev = 8'h00;
      if (start_cmd) begin
         next_count = 16'h0000;
      end else if (wr_count) begin
         next_count = is8 ? {{8{pwdata_i[7]}}, pwdata_i[7:0]} : pwdata_i[15:0];
      end else if (idx_hit) begin
         next_count = 16'h0000;
         ev[`QDC_EV_IDX] = 1'b1;
      end else if (run) begin
         ev[`QDC_EV_BAD] = step_bad;
         if (step_up) begin
            next_count = is8 ? {{8{cnt_inc[7]}}, cnt_inc[7:0]} : cnt_inc;
            ev[`QDC_EV_OVF] = at_max;
         end else if (step_dn) begin
            next_count = is8 ? {{8{cnt_dec[7]}}, cnt_dec[7:0]} : cnt_dec;
            ev[`QDC_EV_UNF] = at_min;
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         count <= 16'h0000;
      end else begin
         count <= next_count;
      end
   end

   // ====================================================================
   // sticky status; a new event wins over the read clear
   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         status <= 8'h00;
      end else if (rd_status) begin
         status <= (status & ~shown) | ev;
      end else begin
         status <= status | ev;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n) begin
      if (!rst_n) begin
         irq_o <= 1'b0;
      end else begin
         irq_o <= |(status & eff_mask);
      end
   end

   // ====================================================================
   // checks
   sequence s_count_write;
      wr_count && !start_cmd;
   endsequence

   a_start_zero: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      start_cmd |=> (count == 16'h0000) && run)
      else $error("start did not zero the counter");
   a_stop_holds: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      (!run && !wr_count && !start_cmd) |=> $stable(count))
      else $error("counter moved while stopped");
   a_count_load: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      s_count_write ##1 1'b1 |-> count[7:0] == $past(pwdata_i[7:0]))
      else $error("count write not loaded");
   a_cw_step: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      (run && !is8 && step_up && !at_max && !idx_hit && !wr_ctrl && !wr_count)
      |=> count == $past(count) + 16'h0001)
      else $error("clockwise step did not count up");
   a_ovf_wrap: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      (run && !is8 && step_up && at_max && !idx_hit && !wr_ctrl && !wr_count)
      |=> count == 16'h8000 && status[`QDC_EV_OVF])
      else $error("overflow not wrapped or flagged");
   a_index_zero: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      (idx_hit && !wr_ctrl && !wr_count) |=> count == 16'h0000 && status[`QDC_EV_IDX])
      else $error("index did not zero the counter");
   a_read_clear: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      (rd_status && ev == 8'h00) |=> (status & $past(shown)) == 8'h00)
      else $error("status read did not clear reported bits");
   a_flag_sticky: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      (status[`QDC_EV_BAD] && !rd_status) |=> status[`QDC_EV_BAD])
      else $error("event flag dropped without a read");
   a_irq_gate: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      ##1 irq_o == $past(|(status & eff_mask)))
      else $error("interrupt does not follow masked status");
   a_mask_forced: assert property (@(posedge core_clk_i) disable iff (!rst_n)
      (psel_i && !penable_i && !pwrite_i && is32 && paddr_i == `QDC_OFS_MASK)
      |=> prdata_o[2:0] == 3'h7)
      else $error("forced mask bits not read as one");
endmodule : qdc_top
`default_nettype wire

// *** bench/qdc_encoder_model.sv ***
// behavioural incremental encoder with index, driving the decoder pins
`timescale 1ns/1ns
`default_nettype none

module qdc_encoder_model (
   input wire logic clk_i,
   output logic phase_a_o,
   output logic phase_b_o,
   output logic index_o
);
   // ====================================================================
   // position on the gray cycle: 0=00, 1=01, 2=11, 3=10 as (a,b)
   logic [1:0] pos;

   initial begin
      pos = 2'h0;
      phase_a_o = 1'b0;
      phase_b_o = 1'b0;
      index_o = 1'b1;
   end

   // ====================================================================
   // level changes, each held 12 cycles so that the filtered path settles
   task automatic put(input logic [1:0] p);
      @(posedge clk_i);
      pos = p;
      phase_a_o <= p[1];
      phase_b_o <= p[1] ^ p[0];
      repeat (12) @(posedge clk_i);
   endtask : put

   // forward moves b ahead of a
   task automatic step(input logic fwd, input int n);
      for (int i = 0; i < n; i++) begin
         put(fwd ? pos + 2'h1 : pos - 2'h1);
      end
   endtask : step

   // both phases at once, never produced by a healthy encoder
   task automatic jump();
      put(pos + 2'h2);
   endtask : jump

   task automatic glitch(input int n);
      @(posedge clk_i);
      phase_a_o <= ~pos[1];
      phase_b_o <= ~(pos[1] ^ pos[0]);
      repeat (n) @(posedge clk_i);
      phase_a_o <= pos[1];
      phase_b_o <= pos[1] ^ pos[0];
      repeat (12) @(posedge clk_i);
   endtask : glitch

   task automatic home();
      while (pos != 2'h0) begin
         put(pos + 2'h1);
      end
   endtask : home

   task automatic set_index(input logic v);
      @(posedge clk_i);
      index_o <= v;
      repeat (12) @(posedge clk_i);
   endtask : set_index
endmodule : qdc_encoder_model
`default_nettype wire

// *** bench/quadrature_decoder_counter_tb.sv ***
// self-checking testbench of the quadrature decoder over apb
`timescale 1ns/1ns
`default_nettype none
`include "qdc_defs.svh"

module quadrature_decoder_counter_tb;
   logic core_clk_i;
   logic rstn_i;
   logic psel;
   logic penable;
   logic pwrite;
   logic [11:0] paddr;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic ph_a;
   logic ph_b;
   logic idx;
   logic irq;
   logic [31:0] rd;
   logic err;
   logic [31:0] saved;
   int num_errors = 0;
   int total_checks = 0;
   int cycles = 0;

   qdc_top i_dut (.core_clk_i(core_clk_i), .rstn_i(rstn_i), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .phase_a_i(ph_a),
      .phase_b_i(ph_b), .index_i(idx), .irq_o(irq));

   qdc_encoder_model i_enc (.clk_i(core_clk_i), .phase_a_o(ph_a), .phase_b_o(ph_b),
      .index_o(idx));

   initial begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end

   // ====================================================================
   // report and compare
   task automatic close_out();
      $display("checks %0d errors %0d", total_checks, num_errors);
      if (num_errors == 0 && total_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : close_out

   task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: word %h expected %h", $time, got, exp);
      end
   endtask : chk_word

   task automatic chk_bit(input logic got, input logic exp);
      total_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: flag %b expected %b", $time, got, exp);
      end
   endtask : chk_bit

   // a hang should end well before this; the full run is well under a thousand cycles
   always @(posedge core_clk_i) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         $display("mismatch at %0t: run too long", $time);
         close_out();
      end
   end

   // ====================================================================
   // apb master
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
         output logic [31:0] rv, output logic e);
      @(posedge core_clk_i);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge core_clk_i);
      penable <= 1'b1;
      // no wait length is assumed: only the bench timeout ends a stuck access
      do begin
         @(posedge core_clk_i);
      end while (pready !== 1'b1);
      rv = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, rd, err);
   endtask : wr

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h0000_0000, rd, err);
      chk_word(rd, exp);
   endtask : rd_chk

   // ====================================================================
   // scenarios
   initial begin
      rstn_i = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      repeat (3) @(posedge core_clk_i);
      rstn_i <= 1'b1;
      repeat (3) @(posedge core_clk_i);
      rd_chk(`QDC_OFS_CTRL, 32'h0000_0072);
      rd_chk(`QDC_OFS_MASK, 32'h0000_0000);
      rd_chk(`QDC_OFS_STATUS, 32'h0000_0000);
      rd_chk(`QDC_OFS_COUNT, 32'h0000_0000);
      apb(1'b0, 12'h010, 32'h0000_0000, rd, err);
      chk_bit(err, 1'b1);
      chk_word(rd, 32'h0000_0000);
      // 16-bit, 4x, no filter, no index
      wr(`QDC_OFS_CTRL, 32'h0000_0013);
      i_enc.step(1'b1, 4);
      rd_chk(`QDC_OFS_COUNT, 32'h0000_0004);
      i_enc.step(1'b0, 6);
      rd_chk(`QDC_OFS_COUNT, 32'hFFFF_FFFE);
      for (int r = 0; r < 3; r++) begin
         wr(`QDC_OFS_CTRL, 32'h0000_0003 | (32'(r) << 3));
         rd_chk(`QDC_OFS_COUNT, 32'h0000_0000);
         i_enc.step(1'b1, 4);
         rd_chk(`QDC_OFS_COUNT, 32'h0000_0001 << r);
      end
      // 8-bit wrap in both directions
      wr(`QDC_OFS_CTRL, 32'h0000_0011);
      wr(`QDC_OFS_COUNT, 32'h0000_007F);
      rd_chk(`QDC_OFS_COUNT, 32'h0000_007F);
      i_enc.step(1'b1, 1);
      rd_chk(`QDC_OFS_COUNT, 32'hFFFF_FF80);
      rd_chk(`QDC_OFS_STATUS, 32'h0000_0001);
      rd_chk(`QDC_OFS_STATUS, 32'h0000_0000);
      i_enc.step(1'b0, 1);
      chk_bit(irq, 1'b0);
      rd_chk(`QDC_OFS_COUNT, 32'h0000_007F);
      rd_chk(`QDC_OFS_STATUS, 32'h0000_0002);
      // mask and interrupt
      wr(`QDC_OFS_CTRL, 32'h0000_0013);
      wr(`QDC_OFS_MASK, 32'h0000_0008);
      rd_chk(`QDC_OFS_MASK, 32'h0000_0008);
      i_enc.jump();
      chk_bit(irq, 1'b1);
      rd_chk(`QDC_OFS_STATUS, 32'h0000_0008);
      repeat (2) @(posedge core_clk_i);
      chk_bit(irq, 1'b0);
      wr(`QDC_OFS_MASK, 32'h0000_0001);
      i_enc.jump();
      chk_bit(irq, 1'b0);
      rd_chk(`QDC_OFS_STATUS, 32'h0000_0008);
      // 32-bit size keeps three enables on
      wr(`QDC_OFS_CTRL, 32'h0000_0015);
      wr(`QDC_OFS_MASK, 32'h0000_0000);
      rd_chk(`QDC_OFS_MASK, 32'h0000_0007);
      wr(`QDC_OFS_COUNT, 32'h0000_7FFF);
      i_enc.step(1'b1, 1);
      chk_bit(irq, 1'b1);
      rd_chk(`QDC_OFS_COUNT, 32'hFFFF_8000);
      rd_chk(`QDC_OFS_STATUS, 32'h0000_0001);
      // filter and index, 16-bit
      wr(`QDC_OFS_CTRL, 32'h0000_0073);
      i_enc.glitch(2);
      rd_chk(`QDC_OFS_COUNT, 32'h0000_0000);
      rd_chk(`QDC_OFS_STATUS, 32'h0000_0000);
      i_enc.step(1'b1, 3);
      rd_chk(`QDC_OFS_COUNT, 32'h0000_0003);
      i_enc.home();
      i_enc.set_index(1'b0);
      rd_chk(`QDC_OFS_COUNT, 32'h0000_0000);
      i_enc.set_index(1'b1);
      rd_chk(`QDC_OFS_STATUS, 32'h0000_0004);
      // stop and restart done by read-modify-write of the control register
      apb(1'b0, `QDC_OFS_CTRL, 32'h0000_0000, saved, err);
      chk_word(saved, 32'h0000_0073);
      wr(`QDC_OFS_CTRL, saved & 32'hFFFF_FFFE);
      rd_chk(`QDC_OFS_CTRL, 32'h0000_0072);
      i_enc.step(1'b1, 2);
      rd_chk(`QDC_OFS_COUNT, 32'h0000_0000);
      rd_chk(`QDC_OFS_STATUS, 32'h0000_0000);
      wr(`QDC_OFS_CTRL, saved);
      i_enc.step(1'b1, 1);
      rd_chk(`QDC_OFS_COUNT, 32'h0000_0001);
      close_out();
   end
endmodule : quadrature_decoder_counter_tb
`default_nettype wire
